/* hdl/spi_sel_pkg.sv */
// constants and types of the spi master with hardware slave select
// Behaviour
// - chained slaves share one active-low select line, all enabled together
// - a chain of n slaves gets n characters per transaction; the code sends n+1 characters for a chain field of n
// - hardware-select enable decides if hardware or software drives select
// - equal data-in and data-out pad selects loop transmit data back via pad
// - hardware-select enable set to 1 lets hardware own the select output
// - select low at least one baud before and after each transfer
// - select high at least one baud between back-to-back frames
// - guard time around a frame lasts one or one and a half baud cycles by mode
// - writing 1 to an enable-clear bit disables that interrupt
// - writing 0 to an enable-clear bit leaves that enable unchanged
// - enable bits read 1 when enabled and 0 when disabled
// - enable-set register at 0x16, reset 0x00, bits 7,3,2,1,0
// - enable-set writes are blocked while access protection is active
package spi_sel_pkg;

  // register offsets
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
  localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_SET = 8'h16;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1A;
  localparam logic [7:0] OFS_DATA = 8'h28;

  // control_first fields
  localparam int SWRST_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int CPHA_BIT = 2;
  localparam int CPOL_BIT = 3;
  localparam int DORD_BIT = 4;
  localparam logic [7:0] CTRL_FIRST_MASK = 8'h1E;

  // control_second fields
  localparam int DATA_IN_PAD_SELECT_LSB = 0;
  localparam int DATA_OUT_PAD_SELECT_LSB = 2;
  localparam int HWSEL_BIT = 4;
  localparam int CHAIN_LSB = 5;

  // interrupt bit positions
  localparam int IRQ_DRE = 0;
  localparam int IRQ_TXC = 1;
  localparam int IRQ_RXC = 2;
  localparam int IRQ_SSL = 3;
  localparam int IRQ_ERR = 7;
  localparam logic [7:0] IRQ_MASK = 8'h8F;

  // reset values
  localparam logic [7:0] CTRL_FIRST_RST = 8'h00;
  localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h03;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;

  // timing in half-baud ticks
  localparam logic [1:0] GUARD_HALF_CPHA0 = 2'h2;
  localparam logic [1:0] GUARD_HALF_CPHA1 = 2'h3;
  localparam logic [1:0] GAP_HALF = 2'h2;
  localparam logic [3:0] HALF_LAST = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_SHIFT = 3'b010,
    ST_WAITD = 3'b011,
    ST_TRAIL = 3'b100,
    ST_GAP = 3'b101
  } fsm_t;

endpackage : spi_sel_pkg

/* hdl/pad_sync.sv */
// two-stage synchroniser for the data pads
module pad_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pads
  input wire logic [3:0] padIn,
  output logic [3:0] padSync
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } sync_t;

  sync_t q;
  sync_t d;

  always_comb begin
    d = q;
    d.s1 = padIn;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign padSync = q.s2;

endmodule : pad_sync

/* hdl/baud_tick.sv */
// half-baud tick generator, one tick every div+1 clocks while running
module baud_tick (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [7:0] div,
  // tick
  output logic tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } baud_t;

  baud_t q;
  baud_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!run) begin
      d.cnt = 8'h00;
    end else if (q.cnt >= div) begin
      d.cnt = 8'h00;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule : baud_tick

/* hdl/spi_sel_master.sv */
// spi master with hardware slave select, chaining and interrupt enables
//
// Design decision made here: the address-and-strobe port.
module spi_sel_master (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  // write protection
  input wire logic peripheralAccessGuard,
  // data pads
  input wire logic [3:0] padIn,
  output logic [3:0] padOut,
  output logic [3:0] padOe,
  // serial clock and select
  output logic sckOut,
  output logic ssNOut,
  output logic ssOe,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic [7:0] ctrlFirst;
    logic [7:0] ctrlSecond;
    logic [7:0] baud;
    logic [7:0] irqEn;
    logic [7:0] flags;
    spi_sel_pkg::fsm_t fsm;
    logic [3:0] halfCnt;
    logic [1:0] guardCnt;
    logic [2:0] charCnt;
    logic [7:0] txHold;
    logic txFull;
    logic [7:0] txSh;
    logic [7:0] rxSh;
    logic [7:0] rxData;
    logic rxFull;
    logic sckPhase;
    logic mosi;
    logic ssN;
    logic [3:0] padOut;
    logic [3:0] padOe;
    logic sck;
    logic ssOe;
    logic irq;
    logic [7:0] rdData;
  } state_t;

  state_t q;
  state_t d;

  logic [3:0] padSync;
  logic tick;
  logic baudRun;

  // the bit that leaves the shifter next
  function automatic logic outBit(input logic [7:0] v, input logic lsb);
    outBit = lsb ? v[0] : v[7];
  endfunction : outBit
  function automatic logic [7:0] shiftOut(input logic [7:0] v,
                                          input logic lsb);
    shiftOut = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction : shiftOut
  function automatic logic [7:0] shiftIn(input logic [7:0] v,
                                         input logic b,
                                         input logic lsb);
    shiftIn = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shiftIn

  pad_sync u_pad_sync (
    .clk(clk),
    .rst_n(rst_n),
    .padIn(padIn),
    .padSync(padSync)
  );

  // the baud counter restarts at every idle so guard times are exact
  assign baudRun = (q.fsm != spi_sel_pkg::ST_IDLE);

  baud_tick u_baud_tick (
    .clk(clk),
    .rst_n(rst_n),
    .run(baudRun),
    .div(q.baud),
    .tick(tick)
  );

  function automatic state_t resetState();
    state_t s;
    s = '0;
    s.ctrlFirst = spi_sel_pkg::CTRL_FIRST_RST;
    s.ctrlSecond = spi_sel_pkg::CTRL_SECOND_RST;
    s.baud = spi_sel_pkg::BAUD_RST;
    s.irqEn = spi_sel_pkg::IRQ_EN_RST;
    s.fsm = spi_sel_pkg::ST_IDLE;
    s.ssN = 1'b1;
    s.sck = 1'b0;
    resetState = s;
  endfunction : resetState

  always_comb begin
    logic en;
    logic cpha;
    logic lsb;
    logic [1:0] guardLen;
    logic rxBit;
    logic [7:0] rxNext;
    logic [7:0] evt;
    logic [7:0] clr;
    logic load;
    logic wrOk;
    logic idle;
    logic swReset;
    en = 1'b0;
    cpha = 1'b0;
    lsb = 1'b0;
    guardLen = spi_sel_pkg::GUARD_HALF_CPHA0;
    rxBit = 1'b0;
    rxNext = 8'h00;
    evt = 8'h00;
    clr = 8'h00;
    load = 1'b0;
    wrOk = 1'b0;
    idle = 1'b0;
    swReset = 1'b0;
    d = q;
    en = q.ctrlFirst[spi_sel_pkg::ENABLE_BIT];
    cpha = q.ctrlFirst[spi_sel_pkg::CPHA_BIT];
    lsb = q.ctrlFirst[spi_sel_pkg::DORD_BIT];
    guardLen = cpha ? spi_sel_pkg::GUARD_HALF_CPHA1
                    : spi_sel_pkg::GUARD_HALF_CPHA0;
    rxBit = padSync[q.ctrlSecond[spi_sel_pkg::DATA_IN_PAD_SELECT_LSB +: 2]];
    rxNext = shiftIn(q.rxSh, rxBit, lsb);
    idle = (q.fsm == spi_sel_pkg::ST_IDLE);
    wrOk = wrEn && !peripheralAccessGuard;
    // register writes
    if (wrEn) begin
      case (addr)
        spi_sel_pkg::OFS_CTRL_FIRST: begin
          if (wrOk) begin
            d.ctrlFirst = wrData & spi_sel_pkg::CTRL_FIRST_MASK;
            swReset = wrData[spi_sel_pkg::SWRST_BIT];
          end
        end
        spi_sel_pkg::OFS_CTRL_SECOND: begin
          // pads, select owner and chain length only change when idle
          if (idle) begin
            d.ctrlSecond = wrData;
          end
        end
        spi_sel_pkg::OFS_BAUD: begin
          if (idle) begin
            d.baud = wrData;
          end
        end
        spi_sel_pkg::OFS_IRQ_CLR: begin
          if (wrOk) begin
            d.irqEn = q.irqEn & ~(wrData & spi_sel_pkg::IRQ_MASK);
          end
        end
        spi_sel_pkg::OFS_IRQ_SET: begin
          if (wrOk) begin
            d.irqEn = q.irqEn | (wrData & spi_sel_pkg::IRQ_MASK);
          end
        end
        spi_sel_pkg::OFS_IRQ_FLAGS: begin
          clr = wrData & spi_sel_pkg::IRQ_MASK;
        end
        spi_sel_pkg::OFS_DATA: begin
          // a write into a full holding register is dropped
          if (!q.txFull) begin
            d.txHold = wrData;
            d.txFull = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // register reads, answer stands one cycle
    d.rdData = 8'h00;
    if (rdEn) begin
      case (addr)
        spi_sel_pkg::OFS_CTRL_FIRST: d.rdData = q.ctrlFirst;
        spi_sel_pkg::OFS_CTRL_SECOND: d.rdData = q.ctrlSecond;
        spi_sel_pkg::OFS_BAUD: d.rdData = q.baud;
        spi_sel_pkg::OFS_IRQ_CLR: d.rdData = q.irqEn;
        spi_sel_pkg::OFS_IRQ_SET: d.rdData = q.irqEn;
        spi_sel_pkg::OFS_IRQ_FLAGS: d.rdData = q.flags;
        spi_sel_pkg::OFS_STATUS: begin
          d.rdData = {4'h0, q.ssN, !idle, q.rxFull, q.txFull};
        end
        spi_sel_pkg::OFS_DATA: begin
          d.rdData = q.rxData;
          d.rxFull = 1'b0;
        end
        default: d.rdData = 8'h00;
      endcase
    end
    // frame sequencer
    case (q.fsm)
      spi_sel_pkg::ST_IDLE: begin
        d.ssN = 1'b1;
        if (en && q.txFull) begin
          load = 1'b1;
          d.charCnt = 3'h0;
          d.guardCnt = 2'h0;
          d.fsm = spi_sel_pkg::ST_LEAD;
          if (q.ctrlSecond[spi_sel_pkg::HWSEL_BIT]) begin
            d.ssN = 1'b0;
            evt[spi_sel_pkg::IRQ_SSL] = 1'b1;
          end
        end
      end
      spi_sel_pkg::ST_LEAD: begin
        // lead guard
        // the first shift half tick still belongs to the lead time
        if (tick) begin
          d.guardCnt = q.guardCnt + 2'h1;
          if (d.guardCnt == guardLen - 2'h1) begin
            d.fsm = spi_sel_pkg::ST_SHIFT;
          end
        end
      end
      spi_sel_pkg::ST_SHIFT: begin
        if (tick) begin
          d.halfCnt = q.halfCnt + 4'h1;
          if (!q.halfCnt[0]) begin
            // leading edge
            d.sckPhase = 1'b1;
            if (!cpha) begin
              d.rxSh = rxNext;
            end else begin
              d.mosi = outBit(q.txSh, lsb);
              d.txSh = shiftOut(q.txSh, lsb);
            end
          end else begin
            // trailing edge
            d.sckPhase = 1'b0;
            if (!cpha) begin
              d.txSh = shiftOut(q.txSh, lsb);
              d.mosi = outBit(d.txSh, lsb);
            end else begin
              d.rxSh = rxNext;
            end
          end
          if (q.halfCnt == spi_sel_pkg::HALF_LAST) begin
            d.rxData = d.rxSh;
            d.rxFull = 1'b1;
            evt[spi_sel_pkg::IRQ_RXC] = 1'b1;
            if (q.rxFull) begin
              evt[spi_sel_pkg::IRQ_ERR] = 1'b1;
            end
            if (q.charCnt == q.ctrlSecond[spi_sel_pkg::CHAIN_LSB +: 3]) begin
              d.guardCnt = 2'h0;
              d.fsm = spi_sel_pkg::ST_TRAIL;
            end else begin
              d.charCnt = q.charCnt + 3'h1;
              if (q.txFull) begin
                load = 1'b1;
              end else begin
                d.fsm = spi_sel_pkg::ST_WAITD;
              end
            end
          end
        end
      end
      spi_sel_pkg::ST_WAITD: begin
        // select stays low while the chain waits for its next character
        if (q.txFull) begin
          load = 1'b1;
          d.fsm = spi_sel_pkg::ST_SHIFT;
        end else if (!en) begin
          d.guardCnt = 2'h0;
          d.fsm = spi_sel_pkg::ST_TRAIL;
        end
      end
      spi_sel_pkg::ST_TRAIL: begin
        if (tick) begin
          d.guardCnt = q.guardCnt + 2'h1;
          if (d.guardCnt == guardLen) begin
            d.ssN = 1'b1;
            d.guardCnt = 2'h0;
            evt[spi_sel_pkg::IRQ_TXC] = 1'b1;
            d.fsm = spi_sel_pkg::ST_GAP;
          end
        end
      end
      spi_sel_pkg::ST_GAP: begin
        if (tick) begin
          d.guardCnt = q.guardCnt + 2'h1;
          if (d.guardCnt == spi_sel_pkg::GAP_HALF) begin
            d.fsm = spi_sel_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        d.fsm = spi_sel_pkg::ST_IDLE;
        d.ssN = 1'b1;
      end
    endcase

    // move the holding register into the shifter
    if (load) begin
      d.txSh = q.txHold;
      d.txFull = 1'b0;
      d.mosi = outBit(q.txHold, lsb);
      d.halfCnt = 4'h0;
      d.sckPhase = 1'b0;
      d.rxSh = 8'h00;
      evt[spi_sel_pkg::IRQ_DRE] = 1'b1;
    end
    // sticky flags: a set in the clearing cycle wins
    d.flags = ((q.flags & ~clr) | evt) & spi_sel_pkg::IRQ_MASK;
    if (swReset) begin
      d = resetState();
    end
    // registered pin drive
    d.padOut = 4'h0;
    d.padOe = 4'h0;
    d.padOut[d.ctrlSecond[spi_sel_pkg::DATA_OUT_PAD_SELECT_LSB +: 2]] = d.mosi;
    d.padOe[d.ctrlSecond[spi_sel_pkg::DATA_OUT_PAD_SELECT_LSB +: 2]] =
      d.ctrlFirst[spi_sel_pkg::ENABLE_BIT];
    d.sck = d.ctrlFirst[spi_sel_pkg::CPOL_BIT] ^ d.sckPhase;
    d.ssOe = d.ctrlSecond[spi_sel_pkg::HWSEL_BIT];
    d.irq = |(d.flags & d.irqEn);
    if (q.ctrlFirst[spi_sel_pkg::CPOL_BIT] && !en) begin
      d.sck = d.ctrlFirst[spi_sel_pkg::CPOL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= resetState();
    end else begin
      q <= d;
    end
  end

  assign rdData = q.rdData;
  assign padOut = q.padOut;
  assign padOe = q.padOe;
  assign sckOut = q.sck;
  assign ssNOut = q.ssN;
  assign ssOe = q.ssOe;
  assign irq = q.irq;

endmodule : spi_sel_master

/* testbench/spi_slave_model.sv */
// behavioural spi slave: one shift register that echoes what it received
module spi_slave_model (
  // serial lines
  input wire logic clk,
  input wire logic sck,
  input wire logic ssN,
  input wire logic mosi,
  output logic miso,
  // mode and count
  input wire logic cpol,
  input wire logic cpha,
  output logic [7:0] chars
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h3C;
  logic [2:0] bits = 3'h0;
  logic out = 1'b0;
  logic junk = 1'b0;
  initial chars = 8'h00;
  // a released line must not keep its last bit
  always @(posedge clk) junk <= ~junk;
  assign miso = ssN ? junk : out;
  always @(negedge ssN) out = sh[7];
  always @(sck) begin
    if (!ssN && sck == (cpol ^ !cpha)) begin
      sh = {sh[6:0], mosi};
      bits++;
      if (bits == 3'h0) chars++;
    end else if (!ssN) out = sh[7];
  end
endmodule : spi_slave_model

/* testbench/spi_sel_master_asserts.sv */
// port checks of the spi master: select guards and enable reads
module spi_sel_master_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] rdData,
  input wire logic peripheralAccessGuard,
  // select, clock and interrupt
  input wire logic sckOut,
  input wire logic ssNOut,
  input wire logic ssOe,
  input wire logic irq
);
  logic [7:0] enQ, baudQ, quietQ;
  logic sckQ, ssQ, fallQ, wg;
  int h;
  assign h = baudQ + 1;
  assign wg = wrEn && !peripheralAccessGuard;
  // sck edges outside a frame do not restart the gap count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enQ <= 8'h00;
      baudQ <= spi_sel_pkg::BAUD_RST;
      quietQ <= 8'hFF;
      sckQ <= 1'b0;
      ssQ <= 1'b1;
      fallQ <= 1'b0;
    end else begin
      sckQ <= sckOut;
      ssQ <= ssNOut;
      if (ssNOut != ssQ || (sckOut != sckQ && !ssNOut)) quietQ <= 8'h01;
      else if (quietQ != 8'hFF) quietQ <= quietQ + 8'h01;
      if (ssNOut != ssQ) fallQ <= !ssNOut;
      else if (sckOut != sckQ) fallQ <= 1'b0;
      if (wrEn && addr == spi_sel_pkg::OFS_BAUD) baudQ <= wrData;
      if (wg && addr == spi_sel_pkg::OFS_IRQ_SET)
        enQ <= enQ | (wrData & spi_sel_pkg::IRQ_MASK);
      if (wg && addr == spi_sel_pkg::OFS_IRQ_CLR) enQ <= enQ & ~wrData;
      // a software reset returns enables and divider to their reset values
      if (wg && addr == spi_sel_pkg::OFS_CTRL_FIRST
          && wrData[spi_sel_pkg::SWRST_BIT]) begin
        enQ <= spi_sel_pkg::IRQ_EN_RST;
        baudQ <= spi_sel_pkg::BAUD_RST;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_lead_guard: assert property ((sckOut != sckQ && !ssNOut && fallQ)
    |-> quietQ >= 2 * h && quietQ <= 4 * h) else $error("lead guard");
  a_trail_guard: assert property ((ssNOut && !ssQ && ssOe)
    |-> quietQ >= 2 * h && quietQ <= 4 * h) else $error("trail guard");
  a_frame_gap: assert property ((!ssNOut && ssQ) |-> quietQ >= 2 * h)
    else $error("gap too short");
  a_ss_owned: assert property ((!ssNOut && ssQ) |-> ssOe)
    else $error("select fell unowned");
  a_sck_in_frame: assert property ((sckOut != sckQ && ssOe) |-> !ssNOut)
    else $error("clock outside frame");
  a_rd_idle_zero: assert property (!$past(rdEn) |-> rdData == 8'h00)
    else $error("read data outside slot");
  a_set_read: assert property ((rdEn && addr == spi_sel_pkg::OFS_IRQ_SET)
    |=> rdData == enQ) else $error("enable set read");
  a_clr_read: assert property ((rdEn && addr == spi_sel_pkg::OFS_IRQ_CLR)
    |=> rdData == enQ) else $error("enable clear read");
  a_irq_needs_en: assert property (irq |-> (enQ | $past(enQ)) != 8'h00)
    else $error("irq without enable");
endmodule : spi_sel_master_asserts

bind spi_sel_master spi_sel_master_asserts i_asserts (.clk(clk),
  .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .peripheralAccessGuard(peripheralAccessGuard),
  .sckOut(sckOut), .ssNOut(ssNOut), .ssOe(ssOe), .irq(irq));

/* testbench/spi_sel_master_bench.sv */
// self-checking bench of the spi master with hardware select
module spi_sel_master_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wrEn, rdEn, peripheralAccessGuard, cpha;
  logic [7:0] addr, wrData, rdData, v, w, en, prev, chars, c0;
  logic [3:0] padIn, padOut, padOe;
  logic sckOut, ssNOut, ssOe, irq, miso;
  int seed = 51;
  int fails = 0;
  int checks_done = 0;
  int falls = 0;
  int f0;
  // an enabled pad reads back its own drive, the rest see the slave
  assign padIn = (padOe & padOut) | (~padOe & {4{miso}});
  always @(negedge ssNOut) falls++;
  spi_sel_master i_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .peripheralAccessGuard(peripheralAccessGuard), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .sckOut(sckOut), .ssNOut(ssNOut),
    .ssOe(ssOe), .irq(irq));
  spi_slave_model i_slave (.clk(clk), .sck(sckOut), .ssN(ssNOut),
    .mosi(padOut[0]), .miso(miso), .cpol(1'b0), .cpha(cpha), .chars(chars));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string name, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // polls status until the masked bits clear, bounded
  task automatic wait_clear(input logic [7:0] m);
    logic [7:0] s;
    for (int i = 0; i < 300; i++) begin
      rd(spi_sel_pkg::OFS_STATUS, s);
      if ((s & m) === 8'h00) return;
    end
    fails++;
    tally_and_finish;
  endtask : wait_clear
  task automatic frame(input logic [7:0] tx, exp);
    logic [7:0] d;
    wr(spi_sel_pkg::OFS_DATA, tx);
    wait_clear(8'h05);
    rd(spi_sel_pkg::OFS_DATA, d);
    check("rx data", d, exp);
    $display("frame done");
  endtask : frame
  initial begin
    rst_n = 1'b0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
    peripheralAccessGuard = 1'b0;
    cpha = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(spi_sel_pkg::OFS_IRQ_SET, v);
    check("enable reset", v, 8'h00);
    en = 8'h00;
    for (int i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      wr(i[0] ? spi_sel_pkg::OFS_IRQ_CLR : spi_sel_pkg::OFS_IRQ_SET, v);
      en = i[0] ? en & ~v : en | (v & spi_sel_pkg::IRQ_MASK);
      rd(i[1] ? spi_sel_pkg::OFS_IRQ_CLR : spi_sel_pkg::OFS_IRQ_SET, w);
      check("enables", w, en);
    end
    wr(spi_sel_pkg::OFS_IRQ_CLR, 8'hFF);
    peripheralAccessGuard <= 1'b1;
    wr(spi_sel_pkg::OFS_IRQ_SET, 8'hFF);
    peripheralAccessGuard <= 1'b0;
    rd(spi_sel_pkg::OFS_IRQ_SET, v);
    check("guarded set", v, 8'h00);
    rd(8'h30, v);
    check("unmapped", v, 8'h00);
    $display("register test done");
    check("owner off", {7'h00, ssOe}, 8'h00);
    wr(spi_sel_pkg::OFS_BAUD, 8'h03);
    wr(spi_sel_pkg::OFS_CTRL_SECOND, 8'h12);
    settle;
    check("owner on", {7'h00, ssOe}, 8'h01);
    prev = 8'h3C;
    for (int m = 0; m < 2; m++) begin
      cpha = m[0];
      wr(spi_sel_pkg::OFS_CTRL_FIRST, {5'h00, cpha, 2'b10});
      v = 8'($random(seed));
      frame(v, prev);
      prev = v;
    end
    // second character lands on an unread one: overrun
    v = 8'($random(seed));
    w = 8'($random(seed));
    f0 = falls;
    wr(spi_sel_pkg::OFS_DATA, v);
    wait_clear(8'h01);
    wr(spi_sel_pkg::OFS_DATA, w);
    wait_clear(8'h05);
    check("frames", 8'(falls - f0), 8'h02);
    rd(spi_sel_pkg::OFS_DATA, c0);
    check("rx second", c0, v);
    rd(spi_sel_pkg::OFS_IRQ_FLAGS, c0);
    check("flags", c0, 8'h8F);
    $display("overrun test done");
    wr(spi_sel_pkg::OFS_IRQ_SET, 8'h04);
    settle;
    check("irq on", {7'h00, irq}, 8'h01);
    wr(spi_sel_pkg::OFS_IRQ_CLR, 8'h04);
    settle;
    check("irq masked", {7'h00, irq}, 8'h00);
    wr(spi_sel_pkg::OFS_IRQ_SET, 8'h04);
    wr(spi_sel_pkg::OFS_IRQ_FLAGS, 8'h8F);
    settle;
    check("irq flag gone", {7'h00, irq}, 8'h00);
    $display("interrupt test done");
    wr(spi_sel_pkg::OFS_CTRL_SECOND, 8'h32);
    f0 = falls;
    c0 = chars;
    wr(spi_sel_pkg::OFS_DATA, v);
    wait_clear(8'h01);
    wr(spi_sel_pkg::OFS_DATA, prev);
    wait_clear(8'h05);
    check("chain selects", 8'(falls - f0), 8'h01);
    check("chain chars", chars - c0, 8'h02);
    rd(spi_sel_pkg::OFS_DATA, c0);
    check("chain rx", c0, v);
    $display("chain test done");
    wr(spi_sel_pkg::OFS_CTRL_SECOND, 8'h10);
    v = 8'($random(seed));
    frame(v, v);
    check("pad enable", {4'h0, padOe}, 8'h01);
    // software reset while enables, flags and select owner are all set
    wr(spi_sel_pkg::OFS_CTRL_FIRST, 8'h01);
    rd(spi_sel_pkg::OFS_IRQ_SET, v);
    check("reset enables", v, spi_sel_pkg::IRQ_EN_RST);
    rd(spi_sel_pkg::OFS_CTRL_SECOND, v);
    check("reset owner", v, spi_sel_pkg::CTRL_SECOND_RST);
    check("reset irq", {7'h00, irq}, 8'h00);
    $display("software reset test done");
    tally_and_finish;
  end
endmodule : spi_sel_master_bench
